//--- src/dpc_regs.sv
`timescale 1ns/1ps
module dpc_regs
  import dpc_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output      logic        first_loop_bypass_o,
  output      logic        oscillator_choice_o,
  output      logic        slope_sign_o,
  output      logic        force_mid_voltage_o,
  output      logic [4:0]  first_loop_pump_current_o,
  output      logic        phase_offset_enable_o,
  output      logic [4:0]  phase_offset_o,
  output      logic [4:0]  second_loop_pump_current_o
);
  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_BUSY = 3'b010,
    W_RESP = 3'b100
  } dpc_wst_t;

  dpc_wst_t   wst_r;
  logic       aw_got_r;
  logic       w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] q_path;
  logic [7:0] q_vcxo;
  logic [7:0] q_phase;
  logic [7:0] q_synth;
  logic [1:0] bresp_r;
  dpc_reg_if  wbus ();

  // Byte address = printed index * 4
  function automatic logic [2:0] dpc_decode(input logic [7:0] a);
    logic [2:0] r;
    r = 3'b100;
    if (a[1:0] == 2'b00) begin
      case (a >> DPC_IDX_SHIFT)
        DPC_OFS_PATH:  r = 3'b000;
        DPC_OFS_VCXO:  r = 3'b001;
        DPC_OFS_PHASE: r = 3'b010;
        DPC_OFS_SYNTH: r = 3'b011;
        default:       r = 3'b100;
      endcase
    end
    return r;
  endfunction

  wire [2:0] wdec = dpc_decode(awaddr_r);
  wire [2:0] rdec = dpc_decode(s_axi_araddr);
  wire       both = aw_got_r && w_got_r;

  assign s_axi_awready = (wst_r == W_IDLE) && !aw_got_r;
  assign s_axi_wready  = (wst_r == W_IDLE) && !w_got_r;
  assign s_axi_bvalid  = (wst_r == W_RESP);
  assign s_axi_bresp   = bresp_r;
  assign wbus.wr_en    = (wst_r == W_BUSY) && !wdec[2];
  assign wbus.wr_sel   = wdec[1:0];
  assign wbus.wr_data  = wdata_r[7:0];
  assign wbus.wr_strb  = wstrb_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wst_r    <= W_IDLE;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
      bresp_r  <= RESP_OKAY;
    end else begin
      case (wst_r)
        W_IDLE: begin
          if (s_axi_awvalid && s_axi_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
          end
          if (s_axi_wvalid && s_axi_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
          end
          if (both) begin
            wst_r <= W_BUSY;
          end
        end
        W_BUSY: begin
          bresp_r  <= wdec[2] ? RESP_SLVERR : RESP_OKAY;
          aw_got_r <= 1'b0;
          w_got_r  <= 1'b0;
          wst_r    <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            wst_r <= W_IDLE;
          end
        end
        default: wst_r <= W_IDLE;
      endcase
    end
  end

  dpc_reg8 #(.SEL(2'd0), .RST(RST_PATH), .MASK(MASK_PATH)) u_path (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr        (wbus.regs),
    .q_o       (q_path)
  );
  // Reset value sets force-mid-voltage and pump current 01111
  dpc_reg8 #(.SEL(2'd1), .RST(RST_VCXO), .MASK(MASK_VCXO)) u_vcxo (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr        (wbus.regs),
    .q_o       (q_vcxo)
  );
  dpc_reg8 #(.SEL(2'd2), .RST(RST_PHASE), .MASK(MASK_PHASE)) u_phase (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr        (wbus.regs),
    .q_o       (q_phase)
  );
  dpc_reg8 #(.SEL(2'd3), .RST(RST_SYNTH), .MASK(MASK_SYNTH)) u_synth (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .wr        (wbus.regs),
    .q_o       (q_synth)
  );

  assign first_loop_bypass_o        = q_path[BIT_BYPASS];
  assign oscillator_choice_o        = q_path[BIT_OSC_CHOICE];
  assign slope_sign_o               = q_vcxo[BIT_SLOPE];
  assign force_mid_voltage_o        = q_vcxo[BIT_FORCE_MID];
  assign first_loop_pump_current_o  = q_vcxo[FLD_W-1:0];
  assign phase_offset_enable_o      = q_phase[BIT_OFS_EN];
  // Own flop for the applied offset, zero while disabled
  logic [FLD_W-1:0] offset_r;
  wire              ofs_wr  = wbus.wr_en && (wbus.wr_sel == 2'd2) && wbus.wr_strb[0];
  wire  [FLD_W-1:0] ofs_nxt = wbus.wr_data[BIT_OFS_EN] ? wbus.wr_data[FLD_W-1:0] : '0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      offset_r <= RST_PHASE[BIT_OFS_EN] ? RST_PHASE[FLD_W-1:0] : '0;
    end else if (ofs_wr) begin
      offset_r <= ofs_nxt;
    end
  end

  assign phase_offset_o = offset_r;
  assign second_loop_pump_current_o = q_synth[FLD_W-1:0];

  logic [7:0] rsel;
  assign rsel = (rdec == 3'b000) ? q_path  :
                (rdec == 3'b001) ? q_vcxo  :
                (rdec == 3'b010) ? q_phase :
                (rdec == 3'b011) ? q_synth : 8'h00;

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rsel};
      s_axi_rresp  <= rdec[2] ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  property p_reset_vcxo;
    @(posedge ref_clk_i) $rose(rst_n_i) |-> force_mid_voltage_o && !slope_sign_o
      && (first_loop_pump_current_o == RST_VCXO[FLD_W-1:0]);
  endproperty
  a_reset_vcxo: assert property (p_reset_vcxo) else $error("vcxo reset wrong");

  property p_path_reset;
    @(posedge ref_clk_i) $rose(rst_n_i) |-> !first_loop_bypass_o && !oscillator_choice_o;
  endproperty
  a_path_reset: assert property (p_path_reset) else $error("path reset wrong");

  property p_bypass_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wbus.wr_en && wbus.wr_sel == 2'd0 && wbus.wr_strb[0]
      |=> first_loop_bypass_o == $past(wbus.wr_data[BIT_BYPASS]);
  endproperty
  a_bypass_wr: assert property (p_bypass_wr) else $error("bypass not written");

  property p_osc_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wbus.wr_en && wbus.wr_sel == 2'd0 && wbus.wr_strb[0]
      |=> oscillator_choice_o == $past(wbus.wr_data[BIT_OSC_CHOICE]);
  endproperty
  a_osc_wr: assert property (p_osc_wr) else $error("osc choice not written");

  property p_slope_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wbus.wr_en && wbus.wr_sel == 2'd1 && wbus.wr_strb[0]
      |=> slope_sign_o == $past(wbus.wr_data[BIT_SLOPE]);
  endproperty
  a_slope_wr: assert property (p_slope_wr) else $error("slope not written");

  property p_force_hold;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      !(wbus.wr_en && wbus.wr_sel == 2'd1) |=> $stable(force_mid_voltage_o);
  endproperty
  a_force_hold: assert property (p_force_hold) else $error("force bit moved");

  property p_pump_wr;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      wbus.wr_en && wbus.wr_sel == 2'd1 && wbus.wr_strb[0]
      |=> first_loop_pump_current_o == $past(wbus.wr_data[FLD_W-1:0]);
  endproperty
  a_pump_wr: assert property (p_pump_wr) else $error("pump current not written");

  property p_offset_gate;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      phase_offset_o == (phase_offset_enable_o ? q_phase[FLD_W-1:0] : 5'h00);
  endproperty
  a_offset_gate: assert property (p_offset_gate) else $error("offset leaks");

  property p_reserved_zero;
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000 && (q_vcxo & ~MASK_VCXO) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
endmodule

//--- src/dpc_pkg.sv
// Functional notes
// - First-loop bypass resets to 0; writing 1 bypasses the first loop.
// - Oscillator choice 0 selects fixed oscillator, 1 selects tunable one; reset 0.
// - Slope sign resets 0 positive; 1 inverts loop drive sense.
// - Force-mid-voltage 1 holds loop filter output at half supply.
// - Force-mid-voltage bit comes up set to 1 after reset.
// - First-loop pump current is 50 uA times field plus one; reset 01111.
// - Phase-offset enable 1 applies static offset field; 0 applies none.
package dpc_pkg;
  localparam logic [7:0] DPC_OFS_PATH   = 8'h18;
  localparam logic [7:0] DPC_OFS_VCXO   = 8'h1c;
  localparam logic [7:0] DPC_OFS_PHASE  = 8'h1d;
  localparam logic [7:0] DPC_OFS_SYNTH  = 8'h1e;
  // Index constants: printed offsets are not all word aligned
  localparam int         DPC_ADDR_W     = 8;
  localparam int         DPC_IDX_SHIFT  = 2;
  localparam int         BIT_OSC_CHOICE = 0;
  localparam int         BIT_BYPASS     = 1;
  localparam int         BIT_FORCE_MID  = 6;
  localparam int         BIT_SLOPE      = 7;
  localparam int         BIT_OFS_EN     = 5;
  localparam int         FLD_W          = 5;
  localparam logic [7:0] MASK_PATH      = 8'h03;
  localparam logic [7:0] MASK_VCXO      = 8'hdf;
  localparam logic [7:0] MASK_PHASE     = 8'h3f;
  localparam logic [7:0] MASK_SYNTH     = 8'h1f;
  localparam logic [7:0] RST_PATH       = 8'h00;
  localparam logic [7:0] RST_VCXO       = 8'h4f;
  localparam logic [7:0] RST_PHASE      = 8'h00;
  localparam logic [7:0] RST_SYNTH      = 8'h06;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;
endpackage

//--- src/dpc_reg_if.sv
`timescale 1ns/1ps
interface dpc_reg_if;
  logic       wr_en;
  logic [1:0] wr_sel;
  logic [7:0] wr_data;
  logic [3:0] wr_strb;
  modport bus (output wr_en, output wr_sel, output wr_data, output wr_strb);
  modport regs (input wr_en, input wr_sel, input wr_data, input wr_strb);
endinterface

//--- src/dpc_reg8.sv
`timescale 1ns/1ps
module dpc_reg8
  import dpc_pkg::*;
#(
  parameter logic [1:0] SEL   = 2'd0,
  parameter logic [7:0] RST   = 8'h00,
  parameter logic [7:0] MASK  = 8'hff,
  parameter logic [3:0] LANE  = 4'h1,
  parameter int         SHIFT = 0
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_n_i,
  dpc_reg_if.regs         wr,
  output      logic [7:0] q_o
);
  wire hit = wr.wr_en && (wr.wr_sel == SEL) && ((wr.wr_strb & LANE) != 4'h0);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RST;
    end else if (hit) begin
      q_o <= wr.wr_data & MASK;
    end
  end
endmodule

//--- tb/dpc_regs_tb_top.sv
`timescale 1ns/1ps
module dpc_regs_tb_top;
  import dpc_pkg::*;
  logic        ref_clk_i     = 1'b0;
  logic        rst_n_i       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic        byp, osc, slope, fmid, ofs_en;
  logic [4:0]  pump1, ofs, pump2;
  logic [7:0]  e_path = 8'h00, e_vcxo = 8'h4f, e_phase = 8'h00, e_synth = 8'h06;
  int          errors = 0;
  int          checks = 0;

  dpc_regs u_dpc_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .first_loop_bypass_o(byp),
    .oscillator_choice_o(osc), .slope_sign_o(slope), .force_mid_voltage_o(fmid),
    .first_loop_pump_current_o(pump1), .phase_offset_enable_o(ofs_en),
    .phase_offset_o(ofs), .second_loop_pump_current_o(pump2));

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s resp %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    bit aw_done = 0;
    bit w_done  = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge ref_clk_i);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge ref_clk_i); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge ref_clk_i); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk_i); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Reads back one register and compares every control output with the tracked state
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk_resp(r, RESP_OKAY, "read");
    chk_val(d, {24'h0, exp}, "readback");
    case (a)
      8'h60: e_path = exp;
      8'h70: e_vcxo = exp;
      8'h74: e_phase = exp;
      default: e_synth = exp;
    endcase
    chk_val({12'h0, byp, osc, slope, fmid, pump1, ofs_en, ofs, pump2},
            {12'h0, e_path[1], e_path[0], e_vcxo[7], e_vcxo[6], e_vcxo[4:0], e_phase[5],
             (e_phase[5] ? e_phase[4:0] : 5'h00), e_synth[4:0]}, "outputs");
  endtask

  task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                        input logic [7:0] exp);
    logic [1:0] r;
    axi_wr(a, {24'ha5a5a5, d}, s, r);
    chk_resp(r, RESP_OKAY, "write");
    rd_chk(a, exp);
  endtask

  task automatic t_reset();
    rd_chk(8'h60, 8'h00);
    rd_chk(8'h70, 8'h4f);
    rd_chk(8'h74, 8'h00);
    rd_chk(8'h78, 8'h06);
  endtask

  task automatic t_path();
    wr_chk(8'h60, 8'hff, 4'h1, 8'h03);
    wr_chk(8'h60, 8'h02, 4'h1, 8'h02);
    wr_chk(8'h60, 8'hfd, 4'h1, 8'h01);
  endtask

  task automatic t_vcxo();
    wr_chk(8'h70, 8'h00, 4'h1, 8'h00);
    wr_chk(8'h70, 8'ha3, 4'h1, 8'h83);
    wr_chk(8'h70, 8'h5f, 4'h1, 8'h5f);
  endtask

  task automatic t_phase();
    wr_chk(8'h74, 8'h1a, 4'h1, 8'h1a);
    wr_chk(8'h74, 8'hfa, 4'h1, 8'h3a);
    wr_chk(8'h78, 8'h11, 4'he, 8'h06);
    wr_chk(8'h78, 8'hff, 4'h1, 8'h1f);
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(8'h7c, 32'hffffffff, 4'hf, r);
    chk_resp(r, RESP_SLVERR, "unmapped write");
    axi_rd(8'h7c, d, r);
    chk_resp(r, RESP_SLVERR, "unmapped read");
    chk_val(d, 32'h0, "unmapped data");
    axi_rd(8'h61, d, r);
    chk_resp(r, RESP_SLVERR, "unaligned read");
    rd_chk(8'h78, 8'h1f);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_path();
    t_vcxo();
    t_phase();
    t_unmapped();
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    errors++;
    tally_and_finish();
  end
endmodule
